// ### common/ratl_params.svh
`ifndef RATL_PARAMS_SVH
`define RATL_PARAMS_SVH
// ****************************************
// register byte offsets
// ****************************************
`define RATL_OFF_REF_KIND 8'h00
`define RATL_OFF_ADV_KIND 8'h04
`define RATL_OFF_CHAN 8'h08
`define RATL_OFF_THRESH 8'h0C
`define RATL_OFF_SLOPE 8'h10
`define RATL_OFF_QUIET 8'h14
`define RATL_OFF_START_HOLD 8'h18
`define RATL_OFF_REF_HOLD 8'h1C
`define RATL_OFF_EXPORT 8'h20
`define RATL_OFF_PRETRIG 8'h24
`define RATL_OFF_EDGE_CFG 8'h28
`define RATL_OFF_CMD 8'h2C
`define RATL_OFF_STATUS 8'h30
// ****************************************
// encodings and reset values
// ****************************************
`define RATL_KIND_OFF 10'h258
`define RATL_KIND_EDGE 10'h259
`define RATL_KIND_POWER 10'h25B
`define RATL_KIND_COMMAND 10'h25C
`define RATL_CHAN_ONLY 32'h0000_0000
`define RATL_EXPORT_OFF 4'h0
`define RATL_ZERO_WORD 32'h0000_0000
`define RATL_NUM_LINES 11
`define RATL_CLK_PERIOD_NS 40
`endif

// ### common/ratl_pkg.sv
`default_nettype none
package ratl_pkg;
   typedef logic [9:0] ratl_kind_t;
   typedef logic [31:0] ratl_word_t;
   typedef logic [3:0] ratl_line_sel_t;
   typedef logic [10:0] ratl_lines_t;
endpackage : ratl_pkg
`default_nettype wire

// ### hw/ratl_trigger.sv
// Operation
// RULE1: power trigger watches one channel; channel register only ever holds zero.
// RULE2: reference trigger fires when sampled power crosses the programmed threshold.
// RULE3: slope bit picks rising crossing or falling crossing of threshold.
// RULE4: power trigger armed only after signal stayed quiet for programmed time.
// RULE5: quiet time resets to zero; zero arms immediately without waiting.
// RULE6: accepted reference trigger routed to one chosen line or to none.
// RULE7: after start, reference triggers ignored until start holdoff expires.
// RULE8: after a reference trigger, next ones ignored until reference holdoff expires.
// RULE9: advance type codes 600 none, 601 edge, 604 command.
// RULE10: edge mode advance fires only on selected edge of chosen line.
// RULE11: command mode advance fires only on explicit software command for it.
// RULE12: reference type also offers power-level option coded 603.
// RULE13: reference trigger waits until pretrigger sample count is acquired.
// RULE14: holdoff and quiet times are cycle down-counters gating recognition.
`timescale 1ns/1ps
`default_nettype none
`include "ratl_params.svh"
module ratl_trigger (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire ratl_pkg::ratl_word_t wb_dat_i,
   output ratl_pkg::ratl_word_t wb_dat_o,
   output logic wb_ack_o,
   input wire logic start_i,
   input wire logic power_valid_i,
   input wire logic signed [15:0] power_i,
   input wire ratl_pkg::ratl_lines_t line_i,
   output ratl_pkg::ratl_lines_t line_o,
   output ratl_pkg::ratl_lines_t line_oe_o,
   output logic ref_trig_o,
   output logic adv_trig_o
);
   import ratl_pkg::*;

   // ****************************************
   // register bus
   // ****************************************
   ratl_kind_t ref_kind;
   ratl_kind_t adv_kind;
   logic signed [15:0] thresh;
   logic slope_down;
   ratl_word_t quiet_cfg;
   ratl_word_t start_hold;
   ratl_word_t ref_hold;
   ratl_line_sel_t export_dest;
   ratl_word_t pretrig;
   logic [12:0] edge_cfg;
   ratl_word_t status;
   logic wr, rd;
   ratl_word_t wdat;
   logic sw_ref, sw_adv;

   // byte-lane merge of write data into an old value
   function automatic ratl_word_t merge(input ratl_word_t old, input ratl_word_t nw,
                                        input logic [3:0] sel);
      ratl_word_t r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) r[b*8 +: 8] = nw[b*8 +: 8];
      end
      return r;
   endfunction : merge

   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
   assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
   assign wdat = wb_dat_i;

   // software commands are one-cycle pulses from a write to the command word
   assign sw_ref = wr & (wb_adr_i == `RATL_OFF_CMD) & wb_sel_i[0] & wdat[0];
   assign sw_adv = wr & (wb_adr_i == `RATL_OFF_CMD) & wb_sel_i[0] & wdat[1]; // RULE11

   // ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      end
   end

   // configuration writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_kind <= `RATL_KIND_OFF;
         adv_kind <= `RATL_KIND_OFF;
         thresh <= 16'h0000;
         slope_down <= 1'b0;
         quiet_cfg <= `RATL_ZERO_WORD; // RULE5
         start_hold <= `RATL_ZERO_WORD;
         ref_hold <= `RATL_ZERO_WORD;
         export_dest <= `RATL_EXPORT_OFF;
         pretrig <= `RATL_ZERO_WORD;
         edge_cfg <= 13'h0000;
      end else if (wr) begin
         case (wb_adr_i)
            `RATL_OFF_REF_KIND: ref_kind <= 10'(merge(32'(ref_kind), wdat, wb_sel_i)); // RULE12
            `RATL_OFF_ADV_KIND: adv_kind <= 10'(merge(32'(adv_kind), wdat, wb_sel_i)); // RULE9
            `RATL_OFF_THRESH: thresh <= 16'(merge({16'h0000, thresh}, wdat, wb_sel_i));
            `RATL_OFF_SLOPE: if (wb_sel_i[0]) slope_down <= wdat[0]; // RULE3
            `RATL_OFF_QUIET: quiet_cfg <= merge(quiet_cfg, wdat, wb_sel_i);
            `RATL_OFF_START_HOLD: start_hold <= merge(start_hold, wdat, wb_sel_i);
            `RATL_OFF_REF_HOLD: ref_hold <= merge(ref_hold, wdat, wb_sel_i);
            `RATL_OFF_EXPORT: if (wb_sel_i[0]) export_dest <= wdat[3:0];
            `RATL_OFF_PRETRIG: pretrig <= merge(pretrig, wdat, wb_sel_i);
            `RATL_OFF_EDGE_CFG: edge_cfg <= 13'(merge(32'(edge_cfg), wdat, wb_sel_i));
            default: ;
         endcase
      end
   end

   // read mux, unmapped offsets read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= `RATL_ZERO_WORD;
      end else if (rd) begin
         case (wb_adr_i)
            `RATL_OFF_REF_KIND: wb_dat_o <= {22'h00_0000, ref_kind};
            `RATL_OFF_ADV_KIND: wb_dat_o <= {22'h00_0000, adv_kind};
            `RATL_OFF_CHAN: wb_dat_o <= `RATL_CHAN_ONLY; // RULE1
            `RATL_OFF_THRESH: wb_dat_o <= {16'h0000, thresh};
            `RATL_OFF_SLOPE: wb_dat_o <= {31'h0000_0000, slope_down};
            `RATL_OFF_QUIET: wb_dat_o <= quiet_cfg;
            `RATL_OFF_START_HOLD: wb_dat_o <= start_hold;
            `RATL_OFF_REF_HOLD: wb_dat_o <= ref_hold;
            `RATL_OFF_EXPORT: wb_dat_o <= {28'h000_0000, export_dest};
            `RATL_OFF_PRETRIG: wb_dat_o <= pretrig;
            `RATL_OFF_EDGE_CFG: wb_dat_o <= {19'h0_0000, edge_cfg};
            `RATL_OFF_STATUS: wb_dat_o <= status;
            default: wb_dat_o <= `RATL_ZERO_WORD;
         endcase
      end
   end

   a_chan_zero: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
      rd && wb_adr_i == `RATL_OFF_CHAN |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
      else $error("channel register read nonzero");

   // ****************************************
   // trigger lines: synchronise and find edges
   // ****************************************
   ratl_lines_t ln_s1, ln_s2, ln_q;
   ratl_lines_t ln_rise, ln_fall;

   genvar gi;
   generate
      for (gi = 0; gi < `RATL_NUM_LINES; gi++) begin : g_line
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               ln_s1[gi] <= 1'b0;
               ln_s2[gi] <= 1'b0;
               ln_q[gi] <= 1'b0;
            end else begin
               ln_s1[gi] <= line_i[gi];
               ln_s2[gi] <= ln_s1[gi];
               ln_q[gi] <= ln_s2[gi];
            end
         end
         assign ln_rise[gi] = ln_s2[gi] & ~ln_q[gi];
         assign ln_fall[gi] = ~ln_s2[gi] & ln_q[gi];
      end
   endgenerate

   // pick the edge of one line; out-of-range selections never fire
   function automatic logic pick_edge(input ratl_line_sel_t src, input logic falling,
                                      input ratl_lines_t r, input ratl_lines_t f);
      return (src < 4'(`RATL_NUM_LINES)) && (falling ? f[src] : r[src]);
   endfunction : pick_edge

   logic ref_edge_hit, adv_edge_hit;
   assign ref_edge_hit = pick_edge(edge_cfg[3:0], edge_cfg[4], ln_rise, ln_fall);
   assign adv_edge_hit = pick_edge(edge_cfg[11:8], edge_cfg[12], ln_rise, ln_fall); // RULE10

   // ****************************************
   // power level crossing and quiet time
   // ****************************************
   logic lvl_above, above_now, cross_up, cross_dn, quiet_now, power_hit;
   ratl_word_t quiet_cnt;

   assign above_now = power_i > thresh;
   assign cross_up = power_valid_i & above_now & ~lvl_above; // RULE2
   assign cross_dn = power_valid_i & ~above_now & lvl_above;
   assign quiet_now = slope_down ? lvl_above : ~lvl_above; // RULE4
   assign power_hit = (quiet_cnt == 32'h0000_0000) & (slope_down ? cross_dn : cross_up); // RULE3

   // power level of the last sample
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lvl_above <= 1'b0;
      end else if (power_valid_i) begin
         lvl_above <= above_now;
      end
   end

   // quiet counter reloads while loud, counts down while quiet
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         quiet_cnt <= `RATL_ZERO_WORD;
      end else if (!quiet_now) begin
         quiet_cnt <= quiet_cfg; // RULE14
      end else if (quiet_cnt > quiet_cfg) begin
         quiet_cnt <= quiet_cfg; // RULE5
      end else if (quiet_cnt != 32'h0000_0000) begin
         quiet_cnt <= quiet_cnt - 32'h0000_0001; // RULE4
      end
   end
   a_quiet_arm: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
      ref_trig_o && $past(ref_kind) == `RATL_KIND_POWER
      |-> $past(quiet_cnt) == 32'h0000_0000)
      else $error("power trigger fired before quiet time");
   a_quiet_zero: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
      quiet_cfg == 32'h0000_0000 |=> quiet_cnt == 32'h0000_0000 || $past(wr))
      else $error("zero quiet time did not arm");
   a_power_slope: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
      ref_trig_o && $past(ref_kind) == `RATL_KIND_POWER
      |-> $past(slope_down ? cross_dn : cross_up))
      else $error("power trigger on wrong slope");

   // ****************************************
   // holdoff, pretrigger and reference accept
   // ****************************************
   ratl_word_t hold_cnt;
   ratl_word_t pre_cnt;
   logic started;
   logic ref_hit;
   logic accept;
   logic [7:0] ref_count;
   logic [7:0] adv_count;

   always_comb begin
      case (ref_kind)
         `RATL_KIND_EDGE: ref_hit = ref_edge_hit;
         `RATL_KIND_POWER: ref_hit = power_hit; // RULE12
         `RATL_KIND_COMMAND: ref_hit = sw_ref;
         default: ref_hit = 1'b0;
      endcase
   end

   assign accept = ref_hit & started & (hold_cnt == 32'h0000_0000)
                   & (pre_cnt == 32'h0000_0000) & ~start_i; // RULE7 RULE8 RULE13

   // holdoff counter, start wins over a reference in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold_cnt <= `RATL_ZERO_WORD;
      end else if (start_i) begin
         hold_cnt <= start_hold; // RULE7
      end else if (accept) begin
         hold_cnt <= ref_hold; // RULE8
      end else if (hold_cnt != 32'h0000_0000) begin
         hold_cnt <= hold_cnt - 32'h0000_0001; // RULE14
      end
   end
   a_hold_gate: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
      ref_trig_o |-> $past(hold_cnt) == 32'h0000_0000 && $past(started))
      else $error("reference accepted during holdoff");
   a_start_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
      start_i |=> hold_cnt == $past(start_hold) && !ref_trig_o ##1 !ref_trig_o
      || start_hold < 32'h0000_0002)
      else $error("start holdoff not loaded");
   a_ref_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
      ref_trig_o && !$past(start_i) |-> hold_cnt == $past(ref_hold))
      else $error("reference holdoff not loaded");

   // pretrigger samples still to acquire after start
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_cnt <= `RATL_ZERO_WORD;
         started <= 1'b0;
      end else if (start_i) begin
         pre_cnt <= pretrig; // RULE13
         started <= 1'b1;
      end else if (power_valid_i && pre_cnt != 32'h0000_0000) begin
         pre_cnt <= pre_cnt - 32'h0000_0001;
      end
   end
   a_pretrig_wait: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
      ref_trig_o |-> $past(pre_cnt) == 32'h0000_0000)
      else $error("reference before pretrigger samples");

   // trigger outputs and counters
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_trig_o <= 1'b0;
         adv_trig_o <= 1'b0;
         ref_count <= 8'h00;
         adv_count <= 8'h00;
      end else begin
         ref_trig_o <= accept;
         case (adv_kind)
            `RATL_KIND_EDGE: adv_trig_o <= adv_edge_hit; // RULE10
            `RATL_KIND_COMMAND: adv_trig_o <= sw_adv; // RULE11
            default: adv_trig_o <= 1'b0; // RULE9
         endcase
         if (accept) ref_count <= ref_count + 8'h01;
         if (adv_trig_o) adv_count <= adv_count + 8'h01;
      end
   end
   a_adv_source: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10 RULE11
      adv_trig_o |-> ($past(adv_kind) == `RATL_KIND_EDGE && $past(adv_edge_hit))
      || ($past(adv_kind) == `RATL_KIND_COMMAND && $past(sw_adv)))
      else $error("advance trigger without its source");
   a_kind_off: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
      $past(ref_kind) == `RATL_KIND_OFF |-> !ref_trig_o)
      else $error("reference fired while type is none");

   assign status = {8'h00, adv_count, ref_count, 4'h0, started, pre_cnt != 32'h0000_0000,
                    hold_cnt != 32'h0000_0000, quiet_cnt == 32'h0000_0000};

   // ****************************************
   // export of the reference trigger
   // ****************************************
   ratl_lines_t dest_hot;
   assign dest_hot = (export_dest == `RATL_EXPORT_OFF || export_dest > 4'(`RATL_NUM_LINES))
                     ? 11'h000 : 11'(11'h001 << (export_dest - 4'h1));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         line_o <= 11'h000;
         line_oe_o <= 11'h000;
      end else begin
         line_o <= accept ? dest_hot : 11'h000; // RULE6
         line_oe_o <= accept ? dest_hot : 11'h000;
      end
   end
   a_export_one: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
      line_oe_o != 11'h000 |-> $onehot(line_oe_o) && $past(ref_trig_o) == 1'b0
      && ref_trig_o && line_oe_o == $past(dest_hot))
      else $error("reference export on wrong line");
endmodule : ratl_trigger
`default_nettype wire

// ### verif/ratl_backplane_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// other instruments on shared trigger lines
// ****************************************
module ratl_backplane_model (
   input wire logic clk_i,
   input wire logic clear_i,
   input wire ratl_pkg::ratl_lines_t dev_line_i,
   input wire ratl_pkg::ratl_lines_t dev_oe_i,
   output ratl_pkg::ratl_lines_t line_o,
   output ratl_pkg::ratl_lines_t seen_o
);
   import ratl_pkg::*;
   ratl_lines_t own = 11'h000;
   // wired level: pulled low, high when any party drives it
   assign line_o = own | (dev_line_i & dev_oe_i);
   // collect every line the device has driven since the last clear
   always_ff @(posedge clk_i) begin
      seen_o <= clear_i ? 11'h000 : seen_o | (dev_line_i & dev_oe_i);
   end
   // change one of our own lines just after an edge
   task drive(input int idx, input logic v);
      @(posedge clk_i);
      own[idx] <= v;
   endtask : drive
endmodule : ratl_backplane_model
`default_nettype wire

// ### verif/ratl_trigger_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ratl_trigger_tb_top;
   import ratl_pkg::*;
   // ****************************************
   // signals and instances
   // ****************************************
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, start = 1'b0, pv = 1'b0, clr = 1'b1;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [15:0] pwr = 16'h0000;
   ratl_word_t dat = 32'h0000_0000;
   ratl_word_t wdo;
   logic ack, ref_t, adv_t;
   ratl_lines_t lin, lo, loe, seen;
   int failures = 0, total_checks = 0, ref_cnt = 0, adv_cnt = 0, exp_ref = 0, exp_adv = 0;
   ratl_trigger uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wdo),
      .wb_ack_o(ack), .start_i(start), .power_valid_i(pv), .power_i(pwr), .line_i(lin),
      .line_o(lo), .line_oe_o(loe), .ref_trig_o(ref_t), .adv_trig_o(adv_t));
   ratl_backplane_model bp (.clk_i(clk_i), .clear_i(clr), .dev_line_i(lo), .dev_oe_i(loe),
      .line_o(lin), .seen_o(seen));
   // 25 MHz clock
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   // count trigger pulses
   always @(posedge clk_i) begin
      if (ref_t === 1'b1) ref_cnt++;
      if (adv_t === 1'b1) adv_cnt++;
   end
   // ****************************************
   // tasks
   // ****************************************
   task check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task test_done;
      $display("checks=%0d failures=%0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : test_done
   // classic cycle: hold until ack is sampled, then release
   task wb(input logic w, input logic [7:0] a, input ratl_word_t d, output ratl_word_t r);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) failures++;
      r = wdo;
      cyc <= 1'b0; stb <= 1'b0;
   endtask : wb
   task wr(input logic [7:0] a, input ratl_word_t d);
      ratl_word_t r;
      wb(1'b1, a, d, r);
   endtask : wr
   task rd_chk(input logic [7:0] a, input ratl_word_t e);
      ratl_word_t r;
      wb(1'b0, a, 32'h0000_0000, r);
      check(r, e);
   endtask : rd_chk
   // let pulses land, then compare both tallies
   task tally(input int dr, input int da);
      repeat (3) @(posedge clk_i);
      exp_ref += dr;
      exp_adv += da;
      check(ref_cnt, exp_ref);
      check(adv_cnt, exp_adv);
   endtask : tally
   task cmd(input ratl_word_t d, input int dr, input int da);
      wr(8'h2C, d);
      tally(dr, da);
   endtask : cmd
   task sample(input logic [15:0] p);
      @(posedge clk_i);
      pwr <= p; pv <= 1'b1;
      @(posedge clk_i);
      pv <= 1'b0;
   endtask : sample
   task pulse_start;
      @(posedge clk_i);
      start <= 1'b1;
      @(posedge clk_i);
      start <= 1'b0;
   endtask : pulse_start
   // watchdog
   initial begin
      repeat (4000) @(posedge clk_i);
      failures++;
      test_done();
   end
   // ****************************************
   // tests
   // ****************************************
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      clr <= 1'b0;
      rd_chk(8'h00, 32'h0000_0258);
      rd_chk(8'h04, 32'h0000_0258);
      rd_chk(8'h14, 32'h0000_0000);
      rd_chk(8'h20, 32'h0000_0000);
      wr(8'h08, 32'h0000_0005);
      rd_chk(8'h08, 32'h0000_0000);
      rd_chk(8'h3C, 32'h0000_0000);
      wr(8'h00, 32'h0000_025C);
      cmd(32'h0000_0001, 0, 0);
      wr(8'h18, 32'h0000_0014);
      pulse_start();
      cmd(32'h0000_0001, 0, 0);
      repeat (25) @(posedge clk_i);
      cmd(32'h0000_0001, 1, 0);
      wr(8'h1C, 32'h0000_000A);
      cmd(32'h0000_0001, 1, 0);
      cmd(32'h0000_0001, 0, 0);
      repeat (12) @(posedge clk_i);
      cmd(32'h0000_0001, 1, 0);
      wr(8'h1C, 32'h0000_0000);
      wr(8'h18, 32'h0000_0000);
      wr(8'h24, 32'h0000_0002);
      repeat (12) @(posedge clk_i);
      pulse_start();
      cmd(32'h0000_0001, 0, 0);
      sample(16'h0000);
      sample(16'h0000);
      cmd(32'h0000_0001, 1, 0);
      wr(8'h24, 32'h0000_0000);
      // every export destination, including out-of-range code 12
      for (int d = 0; d < 13; d++) begin
         wr(8'h20, ratl_word_t'(d));
         clr <= 1'b1;
         @(posedge clk_i);
         clr <= 1'b0;
         cmd(32'h0000_0001, 1, 0);
         check(seen, (d > 0 && d < 12) ? 32'h0000_0001 << (d - 1) : 32'h0000_0000);
      end
      wr(8'h00, 32'h0000_025B);
      rd_chk(8'h00, 32'h0000_025B);
      wr(8'h0C, 32'h0000_0064);
      sample(16'h0032);
      sample(16'h0096);
      tally(1, 0);
      wr(8'h10, 32'h0000_0001);
      sample(16'h0032);
      tally(1, 0);
      sample(16'h0096);
      tally(0, 0);
      wr(8'h10, 32'h0000_0000);
      wr(8'h14, 32'h0000_000A);
      sample(16'h0032);
      sample(16'h0096);
      tally(0, 0);
      sample(16'h0032);
      repeat (15) @(posedge clk_i);
      sample(16'h0096);
      tally(1, 0);
      wr(8'h04, 32'h0000_0259);
      wr(8'h28, 32'h0000_0200);
      bp.drive(2, 1'b1);
      repeat (5) @(posedge clk_i);
      tally(0, 1);
      cmd(32'h0000_0002, 0, 0);
      bp.drive(2, 1'b0);
      repeat (5) @(posedge clk_i);
      tally(0, 0);
      wr(8'h04, 32'h0000_025C);
      cmd(32'h0000_0002, 0, 1);
      bp.drive(2, 1'b1);
      repeat (5) @(posedge clk_i);
      tally(0, 0);
      wr(8'h04, 32'h0000_0258);
      cmd(32'h0000_0002, 0, 0);
      // reference on a falling edge of backplane line 3
      wr(8'h00, 32'h0000_0259);
      wr(8'h28, 32'h0000_0013);
      bp.drive(3, 1'b1);
      repeat (5) @(posedge clk_i);
      tally(0, 0);
      bp.drive(3, 1'b0);
      repeat (5) @(posedge clk_i);
      tally(1, 0);
      // status: started, 21 references, 2 advances, quiet time not yet served
      rd_chk(8'h30, 32'h0002_1508);
      test_done();
   end
endmodule : ratl_trigger_tb_top
`default_nettype wire
